/* File: pkg/mem_map_pkg.sv */
package mem_map_pkg;
	// program memory
	localparam logic [15:0] CODE_END_LARGE = 16'h3FFF;
	localparam logic [15:0] CODE_END_SMALL = 16'h1FFF;
	localparam int FACTORY_BYTES = 512;
	localparam logic [15:0] FACTORY_BASE = 16'(CODE_END_LARGE - FACTORY_BYTES + 1);
	localparam logic [15:0] SECURITY_ADDR = 16'h3FF8;
	localparam logic [15:0] DERIV_ID_ADDR = 16'h3FF9;
	localparam logic [15:0] SERIAL_BASE = 16'h3FFC;
	localparam logic [7:0] CODE_BLANK = 8'hFF;
	// internal data memory
	localparam int IRAM_DEPTH = 256;
	localparam int IRAM_AW = 8;
	localparam logic [7:0] BIT_BYTE_BASE = 8'h20;
	localparam logic [7:0] STACK_RESET = 8'h07;
	// special registers handled here
	localparam logic [7:0] SFR_STACK = 8'h81;
	localparam logic [7:0] SFR_CONFIG = 8'h85;
	localparam logic [7:0] SFR_PAGE = 8'hAA;
	localparam int PAGE_BITS = 3;
	localparam logic [2:0] PAGE_RESET = 3'h0;
	localparam int OVERLAY_BIT = 6;
	localparam logic OVERLAY_RESET = 1'b0;
	localparam logic [5:0] CONFIG_LOW_READ = 6'h03;
	// expansion memory and fifo overlay
	localparam int EXP_DEPTH = 1024;
	localparam int EXP_AW = 10;
	localparam logic [7:0] FIFO_PAGE = 8'h04;
	typedef enum logic [3:0] {
		OP_DIRECT, OP_INDIRECT, OP_REG, OP_BIT, OP_PUSH, OP_POP,
		OP_EXT_WIDE, OP_EXT_PAGED, OP_CODE
	} op_type;
endpackage : mem_map_pkg

/* File: core/byte_ram.sv */
`timescale 1ns/1ps
module byte_ram #(
	parameter int DEPTH = 256,
	parameter int AW = 8
) (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic we,
	input wire logic [AW-1:0] addr,
	input wire logic [7:0] wdata,
	output logic [7:0] rdata_q
);
	logic [7:0] mem [DEPTH];

	// array has no reset: contents are undefined at power-up, as in silicon
	always_ff @(posedge clk) begin
		if (we) begin
			mem[addr] <= wdata;
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			rdata_q <= 8'h00;
		end else begin
			rdata_q <= mem[addr];
		end
	end
endmodule : byte_ram

/* File: core/mem_map_decoder.sv */
`timescale 1ns/1ps
// Contract
// R1 - program memory is one block from zero to 0x3FFF or 0x1FFF
// R2 - top 512 bytes of large program memory are factory reserved
// R3 - program memory is read-only, single bytes returned on code reads
// R4 - variant identification byte sits at fixed program address 0x3FF9
// R5 - unique four-byte serial value sits at 0x3FFC to 0x3FFF
// R6 - lower 128 internal bytes reachable by direct and indirect access
// R7 - above 0x7F direct goes to special registers, indirect to upper RAM
// R8 - eight working registers map onto one of four banks in 0x00-0x1F
// R9 - bank select 00,01,10,11 gives bytes 0x00,0x08,0x10,0x18 upward
// R10 - working registers zero and one of active bank serve as pointers
// R11 - bit addresses 0x00-0x7F map to bytes 0x20-0x2F, eight per byte
// R12 - bit or byte access follows the operand type of the instruction
// R13 - push writes at stack pointer plus one, then increments it
// R14 - stack pointer resets to 0x07
// R15 - 1024 expansion bytes reached by wide or paged external moves
// R16 - paged external move takes its high address byte from page select
// R17 - without overlay, upper six address bits ignored, RAM repeats modulo
// R18 - page select is three read/write bits, resets zero, rest read zero
// R19 - overlay enable maps 256 FIFO bytes at 0x0400 to 0x04FF
// R20 - while overlay is enabled expansion RAM at those addresses is hidden
// R21 - software uses the overlay only with USB clock at twice system clock
// R22 - external moves to FIFO space take extra system clock cycles
// R23 - overlay enable is bit 6 of the memory configuration, resets zero
// R24 - core stalls on FIFO moves until a synchronised handshake completes
module mem_map_decoder
	import mem_map_pkg::*;
#(
	parameter logic LARGE_VARIANT = 1'b1,
	parameter logic [7:0] DERIV_ID = 8'h5A // arbitrary value
) (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic req,
	input wire op_type op,
	input wire logic we,
	input wire logic [15:0] addr,
	input wire logic [7:0] wdata,
	input wire logic bank_sel_low,
	input wire logic bank_sel_high,
	input wire logic [31:0] serial_value,
	output logic ack_q,
	output logic [7:0] rdata_q,
	output logic [15:0] code_mem_addr_q,
	input wire logic [7:0] code_mem_data,
	output logic fifo_req_q,
	output logic fifo_we_q,
	output logic [7:0] fifo_addr_q,
	output logic [7:0] fifo_wdata_q,
	input wire logic fifo_ack,
	input wire logic [7:0] fifo_rdata
);
	typedef enum logic [3:0] {
		S_IDLE, S_PTR_RD, S_PTR_WT, S_DECODE, S_IRAM_WT, S_EXP_WT, S_CODE_WT,
		S_FIFO_REQ, S_FIFO_REL
	} state_type;

	function automatic logic [7:0] bank_reg_index(input logic [1:0] bank, input logic [2:0] n);
		bank_reg_index = {3'b000, bank, n};
	endfunction : bank_reg_index

	function automatic logic [7:0] bit_byte(input logic [7:0] bit_addr);
		bit_byte = BIT_BYTE_BASE + {4'h0, bit_addr[6:3]};
	endfunction : bit_byte

	state_type state_q;
	op_type op_q;
	logic we_q;
	logic [15:0] addr_q;
	logic [7:0] wdata_q;
	logic [7:0] stack_pointer_q;
	logic [2:0] page_field_q;
	logic fifo_overlay_enable_q;
	logic fifo_ack_meta_q;
	logic fifo_ack_sync_q;
	logic [7:0] fifo_hold_q;
	logic [1:0] bank;
	logic [7:0] iaddr;
	logic iram_target;
	logic is_ext;
	logic fifo_hit;
	logic sfr_wr;
	logic [15:0] user_end;
	logic iram_we;
	logic [7:0] iram_addr;
	logic [7:0] iram_wdata;
	logic [7:0] iram_q;
	logic exp_we;
	logic [EXP_AW-1:0] exp_addr;
	logic [7:0] exp_q;
	logic [7:0] bit_merged;
	logic [7:0] sfr_rdata;

	assign bank = {bank_sel_high, bank_sel_low}; // R8 R9
	assign is_ext = (op_q == OP_EXT_WIDE) || (op_q == OP_EXT_PAGED);
	assign fifo_hit = is_ext && fifo_overlay_enable_q && (addr_q[15:8] == FIFO_PAGE); // R19 R20
	assign sfr_wr = (state_q == S_DECODE) && (op_q == OP_DIRECT) && addr_q[7] && we_q; // R7
	assign user_end = LARGE_VARIANT ? 16'(FACTORY_BASE - 16'h0001) : CODE_END_SMALL; // R1 R2
	assign exp_addr = addr_q[EXP_AW-1:0]; // R17
	assign bit_merged = iram_q & ~(8'h01 << addr_q[2:0]) | ({7'h00, wdata_q[0]} << addr_q[2:0]);

	// internal RAM address for the pending access
	always_comb begin
		iaddr = addr_q[7:0];
		iram_target = 1'b1;
		case (op_q)
			OP_DIRECT: iram_target = !addr_q[7]; // R6 R7
			OP_REG: iaddr = bank_reg_index(bank, addr_q[2:0]); // R8
			OP_BIT: begin
				iaddr = bit_byte(addr_q[7:0]); // R11
				iram_target = !addr_q[7];
			end
			OP_PUSH: iaddr = stack_pointer_q + 8'h01; // R13
			OP_POP: iaddr = stack_pointer_q;
			OP_INDIRECT: iaddr = addr_q[7:0]; // R6 R7
			default: iram_target = 1'b0;
		endcase
	end

	always_comb begin
		iram_we = 1'b0;
		iram_addr = iaddr;
		iram_wdata = wdata_q;
		exp_we = 1'b0;
		case (state_q)
			S_PTR_RD: iram_addr = bank_reg_index(bank, {2'b00, addr_q[0]}); // R10
			S_DECODE: begin
				iram_we = we_q && iram_target && (op_q != OP_BIT) && (op_q != OP_POP);
				exp_we = we_q && is_ext && !fifo_hit; // R15 R20
			end
			S_IRAM_WT: begin
				// bit writes are read-modify-write of the holding byte
				iram_we = we_q && (op_q == OP_BIT); // R12
				iram_wdata = bit_merged;
			end
			default: iram_we = 1'b0;
		endcase
	end

	always_comb begin
		case (addr_q[7:0])
			SFR_STACK: sfr_rdata = stack_pointer_q;
			SFR_PAGE: sfr_rdata = {5'b00000, page_field_q}; // R18
			SFR_CONFIG: sfr_rdata = {1'b0, fifo_overlay_enable_q, CONFIG_LOW_READ}; // R23
			default: sfr_rdata = 8'h00;
		endcase
	end

	byte_ram #(.DEPTH(IRAM_DEPTH), .AW(IRAM_AW)) u_iram (
		.clk(clk),
		.arst_n(arst_n),
		.we(iram_we),
		.addr(iram_addr),
		.wdata(iram_wdata),
		.rdata_q(iram_q)
	);

	byte_ram #(.DEPTH(EXP_DEPTH), .AW(EXP_AW)) u_exp_ram (
		.clk(clk),
		.arst_n(arst_n),
		.we(exp_we),
		.addr(exp_addr),
		.wdata(wdata_q),
		.rdata_q(exp_q)
	);

	// fifo acknowledge comes from the usb clock domain
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			fifo_ack_meta_q <= 1'b0;
			fifo_ack_sync_q <= 1'b0;
		end else begin
			fifo_ack_meta_q <= fifo_ack;
			fifo_ack_sync_q <= fifo_ack_meta_q; // R24
		end
	end

	// request capture and sequencing
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			state_q <= S_IDLE;
			op_q <= OP_DIRECT;
			we_q <= 1'b0;
			addr_q <= 16'h0000;
			wdata_q <= 8'h00;
		end else begin
			case (state_q)
				S_IDLE: begin
					if (req) begin
						op_q <= op;
						we_q <= we;
						addr_q <= addr;
						wdata_q <= wdata;
						if (op == OP_INDIRECT || op == OP_EXT_PAGED) begin
							state_q <= S_PTR_RD; // R10
						end else begin
							state_q <= S_DECODE;
						end
					end
				end
				S_PTR_RD: state_q <= S_PTR_WT;
				S_PTR_WT: begin
					if (op_q == OP_EXT_PAGED) begin
						addr_q <= {5'b00000, page_field_q, iram_q}; // R16
					end else begin
						addr_q <= {8'h00, iram_q};
					end
					state_q <= S_DECODE;
				end
				S_DECODE: begin
					if (op_q == OP_CODE) begin
						state_q <= S_CODE_WT;
					end else if (fifo_hit) begin
						state_q <= S_FIFO_REQ; // R22
					end else if (is_ext && !we_q) begin
						state_q <= S_EXP_WT;
					end else if (iram_target && (!we_q || op_q == OP_BIT || op_q == OP_POP)) begin
						state_q <= S_IRAM_WT;
					end else begin
						state_q <= S_IDLE;
					end
				end
				S_FIFO_REQ: begin
					if (fifo_ack_sync_q) begin
						state_q <= S_FIFO_REL;
					end
				end
				S_FIFO_REL: begin
					if (!fifo_ack_sync_q) begin
						state_q <= S_IDLE; // R24
					end
				end
				S_IRAM_WT, S_EXP_WT, S_CODE_WT: state_q <= S_IDLE;
				default: state_q <= S_IDLE;
			endcase
		end
	end

	// stack pointer
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			stack_pointer_q <= STACK_RESET; // R14
		end else if (sfr_wr && addr_q[7:0] == SFR_STACK) begin
			stack_pointer_q <= wdata_q;
		end else if (state_q == S_DECODE && op_q == OP_PUSH) begin
			stack_pointer_q <= stack_pointer_q + 8'h01; // R13
		end else if (state_q == S_IRAM_WT && op_q == OP_POP) begin
			stack_pointer_q <= stack_pointer_q - 8'h01;
		end
	end

	// page select, upper bits are not stored so they read zero
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			page_field_q <= PAGE_RESET;
		end else if (sfr_wr && addr_q[7:0] == SFR_PAGE) begin
			page_field_q <= wdata_q[PAGE_BITS-1:0]; // R18
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			fifo_overlay_enable_q <= OVERLAY_RESET;
		end else if (sfr_wr && addr_q[7:0] == SFR_CONFIG) begin
			fifo_overlay_enable_q <= wdata_q[OVERLAY_BIT]; // R23
		end
	end

	// program memory fetch address; array answers combinationally
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			code_mem_addr_q <= 16'h0000;
		end else if (state_q == S_DECODE && op_q == OP_CODE) begin
			code_mem_addr_q <= addr_q; // R3
		end
	end

	// four-phase request toward the usb-clocked fifo; held until acknowledged
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			fifo_req_q <= 1'b0;
			fifo_we_q <= 1'b0;
			fifo_addr_q <= 8'h00;
			fifo_wdata_q <= 8'h00;
			fifo_hold_q <= 8'h00;
		end else if (state_q == S_DECODE && fifo_hit) begin
			fifo_req_q <= 1'b1; // R24
			fifo_we_q <= we_q;
			fifo_addr_q <= addr_q[7:0];
			fifo_wdata_q <= wdata_q;
		end else if (state_q == S_FIFO_REQ && fifo_ack_sync_q) begin
			fifo_req_q <= 1'b0;
			// taken while the usb side still holds ack; after it drops the bytes may move
			fifo_hold_q <= fifo_rdata; // R24
		end
	end

	// answer to the core; the core stalls until ack
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			ack_q <= 1'b0;
			rdata_q <= 8'h00;
		end else begin
			ack_q <= 1'b0;
			case (state_q)
				S_DECODE: begin
					if (op_q == OP_DIRECT && addr_q[7]) begin
						ack_q <= 1'b1; // R7
						rdata_q <= we_q ? rdata_q : sfr_rdata;
					end else if (op_q == OP_BIT && addr_q[7]) begin
						ack_q <= 1'b1;
						rdata_q <= 8'h00;
					end else if (we_q && (op_q != OP_BIT) && (op_q != OP_POP)
						&& (op_q != OP_CODE) && !fifo_hit) begin
						ack_q <= 1'b1;
					end
				end
				S_IRAM_WT: begin
					ack_q <= 1'b1;
					if (op_q == OP_BIT) begin
						rdata_q <= {7'h00, iram_q[addr_q[2:0]]}; // R12
					end else if (!we_q || op_q == OP_POP) begin
						rdata_q <= iram_q;
					end
				end
				S_EXP_WT: begin
					ack_q <= 1'b1;
					rdata_q <= exp_q; // R15
				end
				S_CODE_WT: begin
					ack_q <= 1'b1;
					if (addr_q == DERIV_ID_ADDR) begin
						rdata_q <= DERIV_ID; // R4
					end else if (addr_q[15:2] == SERIAL_BASE[15:2]) begin
						rdata_q <= serial_value[{addr_q[1:0], 3'b000} +: 8]; // R5
					end else if (addr_q <= user_end || addr_q == SECURITY_ADDR) begin
						rdata_q <= code_mem_data; // R1 R3
					end else begin
						rdata_q <= CODE_BLANK; // R2
					end
				end
				S_FIFO_REL: begin
					if (!fifo_ack_sync_q) begin
						ack_q <= 1'b1;
						rdata_q <= fifo_we_q ? rdata_q : fifo_hold_q; // R22
					end
				end
				default: ack_q <= 1'b0;
			endcase
		end
	end

	chk_stack_reset: assert property (@(posedge clk) $rose(arst_n) |-> stack_pointer_q == 8'h07) // R14
		else $error("stack pointer not 0x07 after reset");
	chk_push_incr: assert property (@(posedge clk) disable iff (!arst_n)
		state_q == S_DECODE && op_q == OP_PUSH |-> iram_addr == stack_pointer_q + 8'h01
		##1 stack_pointer_q == $past(stack_pointer_q) + 8'h01) // R13
		else $error("push did not write at pointer plus one");
	chk_page_field: assert property (@(posedge clk) disable iff (!arst_n)
		sfr_wr && addr_q[7:0] == SFR_PAGE |=> page_field_q == $past(wdata_q[2:0])) // R18
		else $error("page select write lost");
	chk_bank_map: assert property (@(posedge clk) disable iff (!arst_n)
		state_q == S_DECODE && op_q == OP_REG |-> iram_addr == {3'b000, bank, addr_q[2:0]}) // R8
		else $error("working register not in active bank");
	chk_bit_map: assert property (@(posedge clk) disable iff (!arst_n)
		op_q == OP_BIT && !addr_q[7] |-> iaddr == 8'h20 + {4'h0, addr_q[6:3]}) // R11
		else $error("bit address maps to wrong byte");
	chk_exp_alias: assert property (@(posedge clk) disable iff (!arst_n)
		exp_we |-> exp_addr == addr_q[9:0] && !fifo_hit) // R17
		else $error("expansion write not modulo or overlaid");
	chk_fifo_hide: assert property (@(posedge clk) disable iff (!arst_n)
		state_q == S_DECODE && fifo_hit |=> fifo_req_q && !ack_q) // R20
		else $error("overlaid access did not go to fifo");
	chk_fifo_stall: assert property (@(posedge clk) disable iff (!arst_n)
		$rose(fifo_req_q) |-> !ack_q throughout (fifo_req_q [*3])) // R24
		else $error("core released during fifo request");
	chk_id_byte: assert property (@(posedge clk) disable iff (!arst_n)
		state_q == S_CODE_WT && addr_q == 16'h3FF9 |=> ack_q && rdata_q == DERIV_ID) // R4
		else $error("identification byte wrong");
	chk_direct_sfr: assert property (@(posedge clk) disable iff (!arst_n)
		state_q == S_DECODE && op_q == OP_DIRECT && addr_q[7] |-> !iram_we ##1 ack_q) // R7
		else $error("direct upper access reached RAM");
endmodule : mem_map_decoder

/* File: dv/fifo_side_model.sv */
`timescale 1ns/1ps
module fifo_side_model (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic req,
	input wire logic we,
	input wire logic [7:0] addr,
	input wire logic [7:0] wdata,
	output logic ack,
	output logic [7:0] rdata,
	input wire logic [15:0] code_addr,
	output logic [7:0] code_data
);
	logic [7:0] mem [256];
	logic [2:0] dly;
	// program array holds an address hash so every byte is predictable
	assign code_data = code_addr[7:0] ^ code_addr[15:8];
	// usb side answers a few cycles late, as a fast but unrelated domain would
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			ack <= 1'b0;
			dly <= 3'h0;
			rdata <= 8'h00;
		end else if (req && !ack) begin
			dly <= dly + 3'h1;
			if (dly == 3'h3) begin
				ack <= 1'b1;
				dly <= 3'h0;
				rdata <= mem[addr];
				if (we) begin
					mem[addr] <= wdata;
				end
			end
		end else if (!req && ack) begin
			ack <= 1'b0;
		end else if (!ack) begin
			rdata <= ~rdata; // released data wiggles so stale bytes never pass
		end
	end
endmodule : fifo_side_model

/* File: dv/mcu_memory_map_decoder_bench.sv */
`timescale 1ns/1ps
`define CHK(nm, ex, gt) begin check_count++; if ((gt) !== (ex)) begin err_total++; \
	$display("unexpected %s exp %h got %h", nm, ex, gt); end end
module mcu_memory_map_decoder_bench
	import mem_map_pkg::*;
;
	localparam logic [7:0] ID = 8'h6C; // arbitrary value
	localparam logic [31:0] SER = 32'hA1B2C3D4;
	logic clk = 1'b0;
	logic arst_n = 1'b0;
	logic req = 1'b0;
	op_type op = OP_DIRECT;
	logic we = 1'b0;
	logic [15:0] addr = 16'h0000;
	logic [7:0] wdata = 8'h00;
	logic bank_sel_low = 1'b0;
	logic bank_sel_high = 1'b0;
	logic ack_q;
	logic [7:0] rdata_q;
	logic [15:0] code_mem_addr_q;
	logic [7:0] code_mem_data;
	logic fifo_req_q, fifo_we_q, fifo_ack;
	logic [7:0] fifo_addr_q, fifo_wdata_q, fifo_rdata;
	int err_total = 0;
	int check_count = 0;
	int lat;
	logic [7:0] got;
	always #50 clk = ~clk;
	mem_map_decoder #(.LARGE_VARIANT(1'b1), .DERIV_ID(ID)) dut_u (.clk(clk), .arst_n(arst_n),
		.req(req), .op(op), .we(we), .addr(addr), .wdata(wdata), .bank_sel_low(bank_sel_low),
		.bank_sel_high(bank_sel_high), .serial_value(SER), .ack_q(ack_q), .rdata_q(rdata_q),
		.code_mem_addr_q(code_mem_addr_q), .code_mem_data(code_mem_data),
		.fifo_req_q(fifo_req_q), .fifo_we_q(fifo_we_q), .fifo_addr_q(fifo_addr_q),
		.fifo_wdata_q(fifo_wdata_q), .fifo_ack(fifo_ack), .fifo_rdata(fifo_rdata));
	fifo_side_model far_u (.clk(clk), .arst_n(arst_n), .req(fifo_req_q), .we(fifo_we_q),
		.addr(fifo_addr_q), .wdata(fifo_wdata_q), .ack(fifo_ack), .rdata(fifo_rdata),
		.code_addr(code_mem_addr_q), .code_data(code_mem_data));
	// one request pulse, then wait for the answer pulse under a bound
	task automatic acc(input op_type o, input logic w, input logic [15:0] a, input logic [7:0] d);
		req <= 1'b1;
		op <= o;
		we <= w;
		addr <= a;
		wdata <= d;
		@(posedge clk);
		req <= 1'b0;
		lat = 0;
		do begin
			@(posedge clk);
			lat++;
		end while (ack_q !== 1'b1 && lat < 200);
		got = rdata_q;
		if (lat >= 200) begin
			err_total++;
			$display("unexpected ack timeout exp 1 got 0");
		end
	endtask : acc
	task automatic t_reset();
		acc(OP_DIRECT, 1'b0, 16'h0081, 8'h00);
		`CHK("stack ptr", 8'h07, got)
		acc(OP_DIRECT, 1'b0, 16'h00AA, 8'h00);
		`CHK("page sel", 8'h00, got)
		acc(OP_DIRECT, 1'b0, 16'h0085, 8'h00);
		`CHK("config", 8'h03, got)
	endtask : t_reset
	task automatic t_stack();
		acc(OP_PUSH, 1'b1, 16'h0000, 8'hA1);
		acc(OP_DIRECT, 1'b0, 16'h0008, 8'h00);
		`CHK("pushed byte", 8'hA1, got)
		acc(OP_DIRECT, 1'b0, 16'h0081, 8'h00);
		`CHK("stack after push", 8'h08, got)
		acc(OP_POP, 1'b0, 16'h0000, 8'h00);
		`CHK("popped byte", 8'hA1, got)
	endtask : t_stack
	task automatic t_banks();
		for (int b = 0; b < 4; b++) begin
			{bank_sel_high, bank_sel_low} <= 2'(b);
			acc(OP_REG, 1'b1, 16'h0000, 8'(8'h40 + b));
			acc(OP_DIRECT, 1'b0, 16'(8 * b), 8'h00);
			`CHK("bank reg", 8'(8'h40 + b), got)
		end
		acc(OP_REG, 1'b1, 16'h0001, 8'h90);
		acc(OP_INDIRECT, 1'b1, 16'h0001, 8'hC3);
		acc(OP_INDIRECT, 1'b0, 16'h0001, 8'h00);
		`CHK("upper ram", 8'hC3, got)
		acc(OP_DIRECT, 1'b0, 16'h0090, 8'h00);
		`CHK("sfr not ram", 8'h00, got)
		acc(OP_REG, 1'b1, 16'h0000, 8'h30);
		acc(OP_DIRECT, 1'b1, 16'h0030, 8'h77);
		acc(OP_INDIRECT, 1'b0, 16'h0000, 8'h00);
		`CHK("lower ram", 8'h77, got)
	endtask : t_banks
	task automatic t_bits();
		acc(OP_DIRECT, 1'b1, 16'h0022, 8'h00);
		acc(OP_BIT, 1'b1, 16'h0013, 8'h01);
		acc(OP_DIRECT, 1'b0, 16'h0022, 8'h00);
		`CHK("bit set byte", 8'h08, got)
		acc(OP_DIRECT, 1'b1, 16'h002F, 8'h80);
		acc(OP_BIT, 1'b0, 16'h007F, 8'h00);
		`CHK("top bit", 8'h01, got)
	endtask : t_bits
	task automatic t_exp_ram();
		acc(OP_DIRECT, 1'b1, 16'h00AA, 8'hFD);
		acc(OP_DIRECT, 1'b0, 16'h00AA, 8'h00);
		`CHK("page field", 8'h05, got)
		{bank_sel_high, bank_sel_low} <= 2'b00;
		acc(OP_REG, 1'b1, 16'h0001, 8'h34);
		acc(OP_EXT_PAGED, 1'b1, 16'h0001, 8'h6E);
		acc(OP_EXT_WIDE, 1'b0, 16'h0534, 8'h00);
		`CHK("paged write", 8'h6E, got)
		acc(OP_EXT_WIDE, 1'b0, 16'hFD34, 8'h00);
		`CHK("alias high", 8'h6E, got)
		acc(OP_EXT_WIDE, 1'b1, 16'h0412, 8'h11);
		acc(OP_EXT_WIDE, 1'b0, 16'h0012, 8'h00);
		`CHK("alias low", 8'h11, got)
	endtask : t_exp_ram
	task automatic t_fifo();
		acc(OP_DIRECT, 1'b1, 16'h0085, 8'h40);
		acc(OP_DIRECT, 1'b0, 16'h0085, 8'h00);
		`CHK("overlay on", 8'h43, got)
		acc(OP_EXT_WIDE, 1'b1, 16'h0412, 8'h99);
		`CHK("fifo stall", 1'b1, lat > 4)
		acc(OP_EXT_WIDE, 1'b0, 16'h0412, 8'h00);
		`CHK("fifo byte", 8'h99, got)
		acc(OP_EXT_WIDE, 1'b0, 16'h0012, 8'h00);
		`CHK("hidden exp ram", 8'h11, got)
		acc(OP_DIRECT, 1'b1, 16'h0085, 8'h00);
	endtask : t_fifo
	task automatic t_code();
		acc(OP_CODE, 1'b0, 16'h0123, 8'h00);
		`CHK("code byte", 8'h22, got)
		acc(OP_CODE, 1'b0, 16'h3FF9, 8'h00);
		`CHK("variant id", ID, got)
		for (int i = 0; i < 4; i++) begin
			acc(OP_CODE, 1'b0, 16'(16'h3FFC + i), 8'h00);
			`CHK("serial", SER[8*i +: 8], got)
		end
		acc(OP_CODE, 1'b0, 16'h3E00, 8'h00);
		`CHK("factory area", 8'hFF, got)
		acc(OP_CODE, 1'b0, 16'h4000, 8'h00);
		`CHK("past end", 8'hFF, got)
	endtask : t_code
	task automatic summarize();
		$display("checks %0d errors %0d", check_count, err_total);
		if (err_total == 0 && check_count > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : summarize
	initial begin
		repeat (6) @(posedge clk);
		arst_n <= 1'b1;
		@(posedge clk);
		t_reset();
		t_stack();
		t_banks();
		t_bits();
		t_exp_ram();
		t_fifo();
		t_code();
		summarize();
	end
	// whole run needs well under 1000 cycles; a hang ends it here
	initial begin
		repeat (20000) @(posedge clk);
		err_total++;
		summarize();
	end
endmodule : mcu_memory_map_decoder_bench
